/* hw/oh_pins.sv */
// Overhead access pins, HDLC byte pins and alarm control for one channel
`timescale 1ns/1ps
`include "oh_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// [RULE1] Rx strobe one clock while overhead valid
// [RULE2] HDLC mode: rx strobe pin carries bit 5
// [RULE3] Tx strobe one clock before overhead sample
// [RULE4] Partner samples tx strobe on falling edge
// [RULE5] Partner drives bit and insert on strobe
// [RULE6] Capture tx bit on next rising edge; code uses ohb_sync[2], the bit from the previous strobe
// [RULE7] HDLC mode: tx strobe pin becomes input
// [RULE8] Alarm command high sends alarm pattern
// [RULE9] Alarm command low sends normal frames
// [RULE10] No insert keeps internal overhead value
module oh_pins
  import oh_pkg::*;
(
  input wire logic core_clk_i, // Core clock 250 MHz
  input wire logic nrst_i, // Async reset, active low
  input wire logic hdlc_mode_i, // High-speed HDLC mode select
  input wire logic rx_bit_i, // Received line bit
  input wire logic rx_oh_flag_i, // Received bit is overhead
  input wire logic [7:0] rx_hdlc_i, // Byte from HDLC receiver
  input wire logic rx_hdlc_vld_i, // HDLC byte valid
  input wire logic tx_overhead_bit_in_i, // Terminal overhead bit
  input wire logic tx_overhead_insert_i, // Terminal insert request
  input wire logic tx_strobe_pin_i, // Tx strobe pin as input
  input wire logic [6:0] tx_hdlc_rest_i, // Other tx HDLC byte bits
  input wire logic tx_alarm_pattern_cmd_i, // Alarm pattern command
  input wire logic tx_payload_i, // Normal payload bit
  output logic rx_overhead_bit_out_o, // Rx overhead data
  output logic rx_overhead_strobe_o, // Rx strobe / HDLC bit 5
  output logic [7:0] rx_frame_ctrl_byte_out_o, // Rx HDLC byte
  output logic tx_overhead_strobe_o, // Tx overhead strobe
  output logic tx_overhead_strobe_oe_o, // Tx strobe pin driven
  output logic [7:0] tx_frame_ctrl_byte_in_o, // Tx HDLC byte gathered
  output logic tx_line_bit_o // Outgoing line bit
);
  typedef struct packed {
    logic [2:0] cmd_sync;
    logic [2:0] ins_sync;
    logic [2:0] ohb_sync;
    logic [2:0] stb_sync;
    logic cmd;
    logic [7:0] pos;
    tx_st_t tx_st;
    logic int_oh;
    logic rx_bit;
    logic rx_stb;
    logic [7:0] rx_byte;
    logic tx_stb;
    logic tx_oe;
    logic [7:0] tx_byte;
    logic line;
  } st_t;
  st_t st_ff;
  st_t nxt_st;
  fifo_if fin();
  fifo_if fout();
  function automatic logic agree(input logic [2:0] s);
    agree = (s[1] == s[2]);
  endfunction
  oh_fifo #(.WIDTH(`OH_FIFO_WIDTH), .DEPTH(`OH_FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .wr(fin),
    .rd(fout)
  );
  assign fin.data = rx_hdlc_i;
  assign fin.valid = rx_hdlc_vld_i;
  assign fout.ready = hdlc_mode_i;
  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.cmd_sync = {st_ff.cmd_sync[1:0], tx_alarm_pattern_cmd_i};
    nxt_st.ins_sync = {st_ff.ins_sync[1:0], tx_overhead_insert_i};
    nxt_st.ohb_sync = {st_ff.ohb_sync[1:0], tx_overhead_bit_in_i};
    nxt_st.stb_sync = {st_ff.stb_sync[1:0], tx_strobe_pin_i};
    if (agree(st_ff.cmd_sync))
      nxt_st.cmd = st_ff.cmd_sync[2];
    nxt_st.pos = (st_ff.pos == `OH_FRAME_BITS - 8'd1) ? 8'h00
                 : st_ff.pos + 8'h01;
    nxt_st.int_oh = st_ff.pos[0];
    // Receive side
    nxt_st.rx_bit = rx_bit_i;
    if (hdlc_mode_i)
    begin
      if (fout.valid)
        nxt_st.rx_byte = fout.data;
      // Pin mirrors the byte even while no new byte arrives
      nxt_st.rx_stb = nxt_st.rx_byte[`OH_RX_BIT]; // RULE2
    end
    else
      nxt_st.rx_stb = rx_oh_flag_i; // RULE1
    // Transmit side
    nxt_st.tx_oe = !hdlc_mode_i; // RULE7
    nxt_st.tx_stb = 1'b0;
    if (hdlc_mode_i)
    begin
      nxt_st.tx_st = st_idle;
      nxt_st.tx_byte = {st_ff.stb_sync[2], tx_hdlc_rest_i}; // RULE7
    end
    else
    begin
      unique case (st_ff.tx_st)
        st_idle:
          if (st_ff.pos == `OH_TX_POS - 8'd2)
          begin
            nxt_st.tx_st = st_strobe;
            nxt_st.tx_stb = 1'b1; // RULE3
          end
        st_strobe:
          nxt_st.tx_st = st_sample;
        st_sample:
          nxt_st.tx_st = st_idle;
        default:
          nxt_st.tx_st = st_idle;
      endcase
    end
    if (st_ff.cmd)
      nxt_st.line = st_ff.pos[0] ^ 1'(`OH_AIS_WORD); // RULE8
    else if (st_ff.tx_st == st_sample)
      nxt_st.line = st_ff.ins_sync[2] ? st_ff.ohb_sync[2] // RULE6
                    : st_ff.int_oh; // RULE10
    else
      nxt_st.line = tx_payload_i; // RULE9
  end
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign rx_overhead_bit_out_o = st_ff.rx_bit;
  assign rx_overhead_strobe_o = st_ff.rx_stb;
  assign rx_frame_ctrl_byte_out_o = st_ff.rx_byte;
  assign tx_overhead_strobe_o = st_ff.tx_stb;
  assign tx_overhead_strobe_oe_o = st_ff.tx_oe;
  assign tx_frame_ctrl_byte_in_o = st_ff.tx_byte;
  assign tx_line_bit_o = st_ff.line;
endmodule

/* common/oh_cfg.svh */
// Constants for the overhead pin block
`ifndef OH_CFG_SVH
`define OH_CFG_SVH
`define OH_FRAME_BITS 8'd85
`define OH_TX_POS 8'd84
`define OH_RX_POS 8'd84
`define OH_FIFO_DEPTH 32
`define OH_FIFO_WIDTH 8
`define OH_AIS_WORD 8'haa
`define OH_RX_BIT 5
`define OH_TX_BIT 7
`endif

/* common/oh_pkg.sv */
// Types for the overhead pin block
package oh_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_strobe = 2'b01,
    st_sample = 2'b10
  } tx_st_t;
endpackage

/* common/fifo_if.sv */
// Valid/ready carrier between framer and its FIFO
`timescale 1ns/1ps
interface fifo_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* hw/oh_fifo.sv */
// Parameterised synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module oh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_i, // Clock
  input wire logic nrst_i, // Async reset, active low
  fifo_if.snk wr, // Fill side
  fifo_if.src rd // Drain side
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fst_t;
  fst_t st_ff;
  fst_t nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;
  assign empty = (st_ff.wp == st_ff.rp);
  assign full = (st_ff.wp[AW] != st_ff.rp[AW]) &&
                (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[st_ff.rp[AW-1:0]];
  always_comb
  begin
    nxt_st = st_ff;
    if (wr.valid && !full)
      nxt_st.wp = st_ff.wp + 1'b1;
    if (rd.ready && !empty)
      nxt_st.rp = st_ff.rp + 1'b1;
  end
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  always_ff @(posedge core_clk_i)
  begin
    if (wr.valid && !full)
      mem[st_ff.wp[AW-1:0]] <= wr.data;
  end
endmodule

/* sim/oh_pins_properties.sv */
// Port assertions for the overhead pin block
`timescale 1ns/1ps
module oh_pins_properties (
  input wire logic core_clk_i, // Clock
  input wire logic nrst_i, // Reset
  input wire logic hdlc_mode_i, // Mode
  input wire logic rx_bit_i, // Rx bit
  input wire logic rx_oh_flag_i, // Rx flag
  input wire logic rx_overhead_bit_out_o, // Rx data
  input wire logic rx_overhead_strobe_o, // Rx strobe
  input wire logic [7:0] rx_frame_ctrl_byte_out_o, // Rx byte
  input wire logic tx_overhead_strobe_o, // Tx strobe
  input wire logic tx_overhead_strobe_oe_o // Tx enable
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  wire logic nh = !hdlc_mode_i;
  rx_data_a: assert property ($past(nrst_i) |->
    rx_overhead_bit_out_o == $past(rx_bit_i)) else $error("rx data");
  rx_strobe_a: assert property (nh && $past(nh) && $past(nrst_i) |->
    rx_overhead_strobe_o == $past(rx_oh_flag_i)) else $error("rx strobe");
  rx_pulse_a: assert property (nh && rx_oh_flag_i ##1 nh && !rx_oh_flag_i
    |=> !rx_overhead_strobe_o) else $error("rx pulse");
  rx_bit5_a: assert property (hdlc_mode_i && $past(hdlc_mode_i) |->
    rx_overhead_strobe_o == rx_frame_ctrl_byte_out_o[5]) else $error("bit5");
  tx_pulse_a: assert property (tx_overhead_strobe_o |=>
    !tx_overhead_strobe_o [*8]) else $error("tx pulse");
  tx_period_a: assert property (tx_overhead_strobe_o && nh |->
    ##85 (tx_overhead_strobe_o || hdlc_mode_i)) else $error("tx period");
  tx_drive_a: assert property (nh && $past(nh) && $past(nrst_i) |->
    tx_overhead_strobe_oe_o) else $error("tx drive");
  tx_input_a: assert property (hdlc_mode_i && $past(hdlc_mode_i) |->
    !tx_overhead_strobe_oe_o) else $error("tx input");
endmodule
bind oh_pins oh_pins_properties i_props (.core_clk_i, .nrst_i, .hdlc_mode_i,
  .rx_bit_i, .rx_oh_flag_i, .rx_overhead_bit_out_o, .rx_overhead_strobe_o,
  .rx_frame_ctrl_byte_out_o, .tx_overhead_strobe_o, .tx_overhead_strobe_oe_o);

/* sim/oh_terminal.sv */
// Terminal equipment model inserting overhead on strobe
`timescale 1ns/1ps
module oh_terminal (
  input wire logic core_clk_i, // Clock
  input wire logic strobe_i, // Tx strobe
  input wire logic use_i, // Insert wanted
  input wire logic want_i, // Bit wanted
  output logic bit_o, // Overhead bit
  output logic ins_o // Insert
);
  initial ins_o = 1'b0;
  initial bit_o = 1'b0;
  always @(negedge core_clk_i)
    if (strobe_i === 1'b1)
    begin
      ins_o <= use_i;
      bit_o <= use_i ? want_i : ~bit_o;
    end
endmodule

/* sim/tb_ds3e3_overhead_hdlc_pins.sv */
// Testbench for the overhead pin block
`timescale 1ns/1ps
module tb_ds3e3_overhead_hdlc_pins;
  logic clk, nrst_n, hd, rb, rf, vld, pin, al, pay, ub, wb, tb, ti, r;
  logic ro, rs, st, oe, ln;
  logic [7:0] hb, rx_b, tx_b;
  logic [6:0] rest;
  int err_count = 0, check_count = 0, i;
  oh_pins i_dut (.core_clk_i(clk), .nrst_i(nrst_n), .hdlc_mode_i(hd),
    .rx_bit_i(rb), .rx_oh_flag_i(rf), .rx_hdlc_i(hb), .rx_hdlc_vld_i(vld),
    .tx_overhead_bit_in_i(tb), .tx_overhead_insert_i(ti),
    .tx_strobe_pin_i(pin), .tx_hdlc_rest_i(rest),
    .tx_alarm_pattern_cmd_i(al), .tx_payload_i(pay),
    .rx_overhead_bit_out_o(ro), .rx_overhead_strobe_o(rs),
    .rx_frame_ctrl_byte_out_o(rx_b), .tx_overhead_strobe_o(st),
    .tx_overhead_strobe_oe_o(oe), .tx_frame_ctrl_byte_in_o(tx_b),
    .tx_line_bit_o(ln));
  oh_terminal i_term (.core_clk_i(clk), .strobe_i(st), .use_i(ub),
    .want_i(wb), .bit_o(tb), .ins_o(ti));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic strobe();
    for (i = 0; i < 200 && st !== 1'b1; i++) tick(1);
    if (st !== 1'b1)
    begin
      err_count++;
      $display("ERROR %0t no tx strobe", $time);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic rx_test();
    {rf, rb} = 2'b11;
    tick(1);
    chk({ro, rs}, 8'h03);
    {rf, rb} = 2'b00;
    tick(1);
    chk({ro, rs}, 8'h00);
  endtask
  task automatic insert_test(input logic w);
    {ub, wb} = {1'b1, w};
    strobe();
    tick(1);
    strobe();
    tick(2);
    chk(ln, w);
  endtask
  task automatic keep_test();
    ub = 1'b0;
    strobe();
    tick(1);
    strobe();
    tick(2);
    r = ln;
    strobe();
    tick(2);
    chk(ln, r);
  endtask
  task automatic alarm_test();
    al = 1'b1;
    strobe();
    tick(10);
    r = ln;
    tick(1);
    chk(ln, {7'h00, ~r});
    {al, pay} = 2'b01;
    tick(20);
    chk(ln, 1'b1);
  endtask
  task automatic fifo_test();
    vld = 1'b1;
    for (int k = 0; k < 33; k++)
    begin
      hb = 8'(k + 1);
      tick(1);
    end
    {vld, hd, pin, rest} = {3'b011, 7'h55};
    tick(60);
    chk(rx_b, 8'h20);
    chk(tx_b, 8'hd5);
  endtask
  initial
  begin
    {nrst_n, hd, rb, rf, vld, pin, al, pay, ub, wb, hb, rest} = '0;
    tick(10);
    nrst_n = 1'b1;
    tick(2);
    rx_test();
    insert_test(1'b1);
    insert_test(1'b0);
    keep_test();
    alarm_test();
    fifo_test();
    print_verdict();
  end
  initial
  begin
    #20000;
    err_count++;
    print_verdict();
  end
endmodule
